// [shared/csp_div_if.sv]
// Carrier between the top and one prescaler instance.
// Assumes all ticks are one-cycle pulses on clk.
interface csp_div_if #(parameter int RW = 6) (input wire logic clk, input wire logic rst_b);
    logic tick_in;
    logic gate;
    logic div_en;
    logic frac;
    logic [RW-1:0] ratio;
    logic tick_out;
    modport core (input clk, rst_b, tick_in, gate, div_en, frac, ratio, output tick_out);
    modport ctl (output tick_in, gate, div_en, frac, ratio, input tick_out);
endinterface

// [shared/csp_pkg.sv]
// Constants of the clock select and prescaler block.
// Assumes a 32-bit APB slave with byte addresses on a 12-bit offset.
package csp_pkg;
    // =====================================================
    // Register offsets
    localparam logic [11:0] CSP_OFF_PLLPRE = 12'h000;
    localparam logic [11:0] CSP_OFF_PLLSEL = 12'h004;
    localparam logic [11:0] CSP_OFF_SRCSEL = 12'h008;
    localparam logic [11:0] CSP_OFF_UPDATE = 12'h00C;
    localparam logic [11:0] CSP_OFF_STATUS = 12'h010;
    localparam logic [11:0] CSP_OFF_USBPRE = 12'h014;
    localparam logic [11:0] CSP_OFF_AHBPRE = 12'h018;
    localparam logic [11:0] CSP_OFF_APB1PRE = 12'h01C;
    localparam logic [11:0] CSP_OFF_APB2PRE = 12'h020;
    localparam logic [11:0] CSP_OFF_MCLKPRE = 12'h024;
    // =====================================================
    // Field positions
    localparam int CSP_DIV_EN_BIT = 0;
    localparam int CSP_PLL_GATE_BIT = 5;
    localparam int CSP_USB_GATE_BIT = 3;
    localparam int CSP_BUS_GATE_BIT = 7;
    localparam int CSP_PLL_RATIO_W = 4;
    localparam int CSP_USB_RATIO_W = 2;
    localparam int CSP_BUS_RATIO_W = 6;
    localparam logic [1:0] CSP_USB_R_DIV2 = 2'h0;
    localparam logic [1:0] CSP_USB_R_DIV1P5 = 2'h2;
    // =====================================================
    // Reset values
    localparam logic [31:0] CSP_REG_RST = 32'h00000000;
    localparam int CSP_FRAC_LAST = 2;
    // =====================================================
    // System clock sources
    typedef enum logic [1:0] {
        CSP_SYS_INT8 = 2'b00,
        CSP_SYS_INT48 = 2'b01,
        CSP_SYS_PLL = 2'b10,
        CSP_SYS_EXT = 2'b11
    } csp_src_t;
endpackage

// [sim/csp_testbench.sv]
// Self-checking bench for the clock select and prescaler block.
// Assumes csp_top as the device, driven over APB and by oscillator ticks from here.
module testbench import csp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic rd; logic err; logic [31:0] data;} csp_note_t;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, fld;
    logic osc8, osc48, oscx, pllo, ok8, ok48, okx, okp;
    logic pll_ref_tick, system_clock, usb_tick, ahb_tick, apb1_tick, apb2_tick, mclk_tick;
    logic [1:0] source_select, prev;
    wire logic [6:0] tk = {system_clock, mclk_tick, apb2_tick, apb1_tick, ahb_tick, usb_tick, pll_ref_tick};
    int err_total, check_count, cyc, r;
    csp_note_t notes[$];
    csp_note_t cur_note;
    localparam logic [11:0] RA [8] = '{CSP_OFF_PLLPRE, CSP_OFF_PLLSEL, CSP_OFF_SRCSEL, CSP_OFF_USBPRE,
        CSP_OFF_AHBPRE, CSP_OFF_APB1PRE, CSP_OFF_APB2PRE, CSP_OFF_MCLKPRE};
    localparam logic [31:0] RM [8] = '{32'h3F, 32'h1, 32'h3, 32'hF, 32'h7F, 32'hFF, 32'hFF, 32'hFF};
    localparam int SP [4] = '{4, 1, 3, 2};
    localparam logic [1:0] SEQ [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
    localparam int USB_D2 [4] = '{4, 6, 3, 6};

    csp_top i_csp_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_8mhz_osc(osc8), .internal_48mhz_osc(osc48), .external_hf_osc(oscx), .pll_out(pllo),
        .internal_8mhz_ok(ok8), .internal_48mhz_ok(ok48), .external_hf_ok(okx), .pll_ok(okp),
        .pll_ref_tick(pll_ref_tick), .system_clock(system_clock), .usb_tick(usb_tick),
        .ahb_tick(ahb_tick), .apb1_tick(apb1_tick), .apb2_tick(apb2_tick), .mclk_tick(mclk_tick),
        .source_select(source_select));

    // =====================================================
    // Clock, oscillator ticks and timeout
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        osc8 <= (cyc % 4 == 3);
        oscx <= (cyc % 2 == 1);
        pllo <= (cyc % 3 == 2);
        osc48 <= 1'b1;
        if (cyc == 60000) begin
            err_total++;
            wrap_up();
        end
    end

    // =====================================================
    // Helpers
    function automatic logic [31:0] xs();
        logic [31:0] s;
        s = seed;
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        seed = s;
        return s;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wrap_up;
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One APB transfer; the expected answer goes to the note queue
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic ee);
        int n;
        notes.push_back('{rd: !wr, err: ee, data: e});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("BAD pready expected 1 seen %b", pready);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Bits 31:8 get random values on every field write
    task automatic wf(input logic [11:0] a, input logic [7:0] f);
        apb(1'b1, a, (xs() & 32'hFFFFFF00) | {24'h0, f}, 32'h0, 1'b0);
    endtask

    // Counts pulses over twenty output periods; d2 is twice the divisor
    task automatic rate(input int idx, input int p, input int d2, input int exp_n);
        int n, tol;
        tol = (exp_n == 0) ? 0 : 1;
        repeat (p * d2 + 4) @(posedge clk);
        n = 0;
        repeat (p * d2 * 10) begin
            @(posedge clk);
            if (tk[idx] === 1'b1)
                n++;
        end
        check_count++;
        if (n < exp_n - tol || n > exp_n + tol) begin
            err_total++;
            $display("BAD tick%0d expected %0d seen %0d", idx, exp_n, n);
        end
    endtask

    // =====================================================
    // Result watcher
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (notes.size() == 0) begin
                err_total++;
                $display("BAD notes expected 1 seen 0");
            end else begin
                cur_note = notes.pop_front();
                if (cur_note.rd)
                    chk("prdata", cur_note.data, prdata);
                chk("pslverr", {31'h0, cur_note.err}, {31'h0, pslverr});
            end
        end
    end

    // =====================================================
    // Main sequence
    initial begin
        seed = 32'h8750D730;
        err_total = 0;
        check_count = 0;
        cyc = 0;
        rst_b = 1'b0;
        {psel, penable, pwrite, osc8, osc48, oscx, pllo} = 7'h00;
        {ok8, ok48, okx, okp} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("source_select", 32'h0, {30'h0, source_select});
        rate(6, 4, 2, 20);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, RA[i], 32'h0, 32'h0, 1'b0);
            apb(1'b1, RA[i], 32'hFFFFFFFF, 32'h0, 1'b0);
            apb(1'b0, RA[i], 32'h0, RM[i], 1'b0);
            apb(1'b1, RA[i], 32'h0, 32'h0, 1'b0);
        end
        apb(1'b0, CSP_OFF_UPDATE, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 12'h030, 32'hFFFFFFFF, 32'h0, 1'b1);
        apb(1'b0, 12'h030, 32'h0, 32'h0, 1'b1);
        prev = 2'h0;
        for (int i = 0; i < 4; i++) begin
            wf(CSP_OFF_SRCSEL, {6'h0, SEQ[i]});
            repeat (8) @(posedge clk);
            chk("source_select", {30'h0, prev}, {30'h0, source_select});
            wf(CSP_OFF_UPDATE, 8'h01);
            repeat (8) @(posedge clk);
            chk("source_select", {30'h0, prev}, {30'h0, source_select});
            apb(1'b0, CSP_OFF_STATUS, 32'h0, {29'h0, 1'b1, prev}, 1'b0);
            case (SEQ[i])
                2'h0: ok8 <= 1'b1;
                2'h1: ok48 <= 1'b1;
                2'h2: okp <= 1'b1;
                default: okx <= 1'b1;
            endcase
            repeat (8) @(posedge clk);
            chk("source_select", {30'h0, SEQ[i]}, {30'h0, source_select});
            apb(1'b0, CSP_OFF_STATUS, 32'h0, {30'h0, SEQ[i]}, 1'b0);
            rate(6, SP[SEQ[i]], 2, 20);
            prev = SEQ[i];
        end
        // System tick now arrives every cycle
        r = 62;
        wf(CSP_OFF_AHBPRE, 8'(r * 2 + 1));
        rate(2, 1, 2 * (r + 2), 20);
        r = xs() % 63;
        wf(CSP_OFF_AHBPRE, 8'(r * 2 + 1));
        rate(2, 1, 2 * (r + 2), 20);
        wf(CSP_OFF_AHBPRE, 8'(r * 2));
        rate(2, 1, 2, 20);
        wf(CSP_OFF_AHBPRE, 8'h01);
        rate(2, 1, 4, 20);
        for (int j = 0; j < 3; j++) begin
            r = (j == 0) ? 62 : xs() % 63;
            wf(RA[5 + j], 8'h81 | 8'(r * 2));
            rate(3 + j, 1, 2 * (r + 2), 20);
            wf(RA[5 + j], 8'h80 | 8'(r * 2));
            rate(3 + j, 1, 2, 20);
            wf(RA[5 + j], 8'h01 | 8'(r * 2));
            rate(3 + j, 1, 2, 0);
        end
        for (int c = 0; c < 4; c++) begin
            wf(CSP_OFF_USBPRE, 8'h09 | 8'(c * 2));
            rate(1, 1, USB_D2[c], 20);
        end
        wf(CSP_OFF_USBPRE, 8'h08);
        rate(1, 1, 2, 20);
        wf(CSP_OFF_USBPRE, 8'h07);
        rate(1, 1, 2, 0);
        for (int s = 0; s < 2; s++) begin
            wf(CSP_OFF_PLLSEL, 8'(s));
            r = (s == 0) ? 14 : xs() % 15;
            wf(CSP_OFF_PLLPRE, 8'h21 | 8'(r * 2));
            rate(0, 4 - 2 * s, 2 * (r + 2), 20);
            wf(CSP_OFF_PLLPRE, 8'h20 | 8'(r * 2));
            rate(0, 4 - 2 * s, 2, 20);
            wf(CSP_OFF_PLLPRE, 8'h01 | 8'(r * 2));
            rate(0, 4 - 2 * s, 2, 0);
        end
        wrap_up();
    end
endmodule

// [src/csp_prescaler.sv]
// Gated tick divider: ratio+2, or 2 of 3 ticks in fraction mode.
// Assumes input ticks are same-domain one-cycle pulses.
module csp_prescaler import csp_pkg::*; #(
    parameter int RW = 6
) (
    // Carrier
    csp_div_if.core d
);
    if (RW < 1 || RW > 9) begin : g_bad
        $error("csp_prescaler: RW out of range");
    end

    logic [RW:0] cnt_r;
    logic [RW:0] cnt_nxt;
    logic out_r;
    logic out_nxt;
    wire [RW:0] limit = {1'b0, d.ratio} + {{RW{1'b0}}, 1'b1};
    wire [RW:0] last = d.frac ? (RW+1)'(CSP_FRAC_LAST) : limit;
    wire at_last = (cnt_r >= last);

    always_comb begin
        cnt_nxt = cnt_r;
        out_nxt = 1'b0;
        if (!d.gate) begin
            cnt_nxt = '0;
        end else if (!d.div_en) begin
            cnt_nxt = '0;
            out_nxt = d.tick_in;
        end else if (d.tick_in) begin
            cnt_nxt = at_last ? '0 : cnt_r + 1'b1;
            out_nxt = d.frac ? !at_last : at_last;
        end
    end

    always_ff @(posedge d.clk) begin
        if (!d.rst_b) begin
            cnt_r <= '0;
            out_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign d.tick_out = out_r;
endmodule

// [src/csp_switch.sv]
// System clock source switch with pending update request.
// Assumes stable flags are already synchronised.
module csp_switch import csp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request
    input wire logic req,
    input wire logic [1:0] sel,
    input wire logic [3:0] stable,
    // State
    output csp_src_t cur,
    output logic pending
);
    csp_src_t cur_r;
    csp_src_t tgt_r;
    logic pend_r;
    wire done = pend_r && stable[tgt_r];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur_r <= CSP_SYS_INT8;
            tgt_r <= CSP_SYS_INT8;
            pend_r <= 1'b0;
        end else begin
            if (done) begin
                cur_r <= tgt_r;
            end
            if (req) begin
                tgt_r <= csp_src_t'(sel);
                pend_r <= 1'b1;
            end else if (done) begin
                pend_r <= 1'b0;
            end
        end
    end

    assign cur = cur_r;
    assign pending = pend_r;
endmodule

// [src/csp_top.sv]
// Clock source select and prescaler front end with APB registers.
// Assumes oscillator ticks come from clk-domain logic; stable flags are asynchronous.
//
// Functional notes
// - PLL reference prescaler passes its input only while bit 5 is one.
// - PLL reference ratio in bits 4:1 divides by value plus two.
// - PLL reference division applies only while bit 0 is one.
// - PLL reference select: zero picks 8 MHz internal, one picks external oscillator.
// - System source field 00 8 MHz, 01 48 MHz, 10 PLL, 11 external.
// - Running source changes only after software writes one to update bit.
// - Update bit clears itself once the switch is taken over.
// - Switch completes only when target reports stable; old source runs meanwhile.
// - After reset the system clock runs from the 8 MHz internal oscillator.
// - USB prescaler receives input only while bit 3 is one.
// - USB ratio bits 2:1: 00 divide 2, 10 divide 1.5, else 3.
// - USB division applies only while bit 0 is one.
// - AHB ratio bits 6:1 divides by value plus two; no input gate.
// - AHB division applies only while bit 0 is one.
// - APB1 prescaler receives input only while bit 7 is one.
// - APB1 ratio bits 6:1 divides by value plus two.
// - APB1 division applies only while bit 0 is one.
// - APB2 prescaler receives input only while bit 7 is one.
// - APB2 ratio bits 6:1 divides by value plus two when enabled.
// - Audio master clock prescaler receives input only while bit 7 is one.
// - Audio master clock ratio bits 6:1 divides by value plus two when enabled.
//
// Local design decision: the APB register port.
module csp_top import csp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator ticks
    input wire logic internal_8mhz_osc,
    input wire logic internal_48mhz_osc,
    input wire logic external_hf_osc,
    input wire logic pll_out,
    // Oscillator stable flags
    input wire logic internal_8mhz_ok,
    input wire logic internal_48mhz_ok,
    input wire logic external_hf_ok,
    input wire logic pll_ok,
    // Divided ticks
    output logic pll_ref_tick,
    output logic system_clock,
    output logic usb_tick,
    output logic ahb_tick,
    output logic apb1_tick,
    output logic apb2_tick,
    output logic mclk_tick,
    output logic [1:0] source_select
);
    // =====================================================
    // Register state
    logic [5:0] pllpre_r;
    logic pllsel_r;
    logic [1:0] srcsel_r;
    logic [3:0] usbpre_r;
    logic [6:0] ahbpre_r;
    logic [7:0] apb1pre_r;
    logic [7:0] apb2pre_r;
    logic [7:0] mclkpre_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic sys_tick_r;
    logic [1:0] cur_src_r;
    logic [3:0] stab_s1_r;
    logic [3:0] stab_s2_r;

    // =====================================================
    // APB decode
    wire setup = psel && !penable;
    wire wr_go = psel && penable && pready_r && pwrite;
    wire hit_pllpre = (paddr == CSP_OFF_PLLPRE);
    wire hit_pllsel = (paddr == CSP_OFF_PLLSEL);
    wire hit_srcsel = (paddr == CSP_OFF_SRCSEL);
    wire hit_update = (paddr == CSP_OFF_UPDATE);
    wire hit_status = (paddr == CSP_OFF_STATUS);
    wire hit_usbpre = (paddr == CSP_OFF_USBPRE);
    wire hit_ahbpre = (paddr == CSP_OFF_AHBPRE);
    wire hit_apb1pre = (paddr == CSP_OFF_APB1PRE);
    wire hit_apb2pre = (paddr == CSP_OFF_APB2PRE);
    wire hit_mclkpre = (paddr == CSP_OFF_MCLKPRE);
    wire mapped = hit_pllpre || hit_pllsel || hit_srcsel || hit_update || hit_status
        || hit_usbpre || hit_ahbpre || hit_apb1pre || hit_apb2pre || hit_mclkpre;
    wire upd_req = wr_go && hit_update && pwdata[0];

    // =====================================================
    // Switch state
    csp_src_t cur_src;
    logic sw_pending;

    csp_switch u_switch (
        .clk(clk),
        .rst_b(rst_b),
        .req(upd_req),
        .sel(srcsel_r),
        .stable(stab_s2_r),
        .cur(cur_src),
        .pending(sw_pending)
    );

    // Update bit is write-only: it reads as zero, pending shows in status
    wire [31:0] rd_mux =
        hit_pllpre ? {26'h0, pllpre_r} :
        hit_pllsel ? {31'h0, pllsel_r} :
        hit_srcsel ? {30'h0, srcsel_r} :
        hit_status ? {29'h0, sw_pending, cur_src} :
        hit_usbpre ? {28'h0, usbpre_r} :
        hit_ahbpre ? {25'h0, ahbpre_r} :
        hit_apb1pre ? {24'h0, apb1pre_r} :
        hit_apb2pre ? {24'h0, apb2pre_r} :
        hit_mclkpre ? {24'h0, mclkpre_r} : 32'h00000000;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata_r <= CSP_REG_RST;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            if (setup) begin
                prdata_r <= pwrite ? 32'h00000000 : rd_mux;
                pslverr_r <= !mapped;
            end
        end
    end

    // =====================================================
    // Register writes, only defined fields stored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pllpre_r <= CSP_REG_RST[5:0];
            pllsel_r <= CSP_REG_RST[0];
            srcsel_r <= CSP_REG_RST[1:0];
            usbpre_r <= CSP_REG_RST[3:0];
            ahbpre_r <= CSP_REG_RST[6:0];
            apb1pre_r <= CSP_REG_RST[7:0];
            apb2pre_r <= CSP_REG_RST[7:0];
            mclkpre_r <= CSP_REG_RST[7:0];
        end else if (wr_go) begin
            if (hit_pllpre) begin
                pllpre_r <= pwdata[5:0];
            end else if (hit_pllsel) begin
                pllsel_r <= pwdata[0];
            end else if (hit_srcsel) begin
                srcsel_r <= pwdata[1:0];
            end else if (hit_usbpre) begin
                usbpre_r <= pwdata[3:0];
            end else if (hit_ahbpre) begin
                ahbpre_r <= pwdata[6:0];
            end else if (hit_apb1pre) begin
                apb1pre_r <= pwdata[7:0];
            end else if (hit_apb2pre) begin
                apb2pre_r <= pwdata[7:0];
            end else if (hit_mclkpre) begin
                mclkpre_r <= pwdata[7:0];
            end
        end
    end

    // =====================================================
    // Stable flag synchronisers and source mux
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stab_s1_r <= 4'h0;
            stab_s2_r <= 4'h0;
        end else begin
            stab_s1_r <= {external_hf_ok, pll_ok, internal_48mhz_ok, internal_8mhz_ok};
            stab_s2_r <= stab_s1_r;
        end
    end

    wire [3:0] src_ticks = {external_hf_osc, pll_out, internal_48mhz_osc, internal_8mhz_osc};
    wire sys_src_tick = src_ticks[cur_src];
    wire pll_in_tick = pllsel_r ? external_hf_osc : internal_8mhz_osc;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sys_tick_r <= 1'b0;
            cur_src_r <= CSP_SYS_INT8;
        end else begin
            sys_tick_r <= sys_src_tick;
            cur_src_r <= cur_src;
        end
    end

    // =====================================================
    // Prescalers
    csp_div_if #(.RW(CSP_PLL_RATIO_W)) pll_if (.clk(clk), .rst_b(rst_b));
    csp_div_if #(.RW(CSP_USB_RATIO_W)) usb_if (.clk(clk), .rst_b(rst_b));
    csp_div_if #(.RW(CSP_BUS_RATIO_W)) ahb_if (.clk(clk), .rst_b(rst_b));
    csp_div_if #(.RW(CSP_BUS_RATIO_W)) apb1_if (.clk(clk), .rst_b(rst_b));
    csp_div_if #(.RW(CSP_BUS_RATIO_W)) apb2_if (.clk(clk), .rst_b(rst_b));
    csp_div_if #(.RW(CSP_BUS_RATIO_W)) mclk_if (.clk(clk), .rst_b(rst_b));

    wire [1:0] usb_ratio = usbpre_r[2:1];

    assign pll_if.tick_in = pll_in_tick;
    assign pll_if.gate = pllpre_r[CSP_PLL_GATE_BIT];
    assign pll_if.div_en = pllpre_r[CSP_DIV_EN_BIT];
    assign pll_if.frac = 1'b0;
    assign pll_if.ratio = pllpre_r[4:1];

    assign usb_if.tick_in = sys_src_tick;
    assign usb_if.gate = usbpre_r[CSP_USB_GATE_BIT];
    assign usb_if.div_en = usbpre_r[CSP_DIV_EN_BIT];
    assign usb_if.frac = (usb_ratio == CSP_USB_R_DIV1P5);
    assign usb_if.ratio = (usb_ratio == CSP_USB_R_DIV2) ? 2'h0 : 2'h1;

    assign ahb_if.tick_in = sys_src_tick;
    assign ahb_if.gate = 1'b1;
    assign ahb_if.div_en = ahbpre_r[CSP_DIV_EN_BIT];
    assign ahb_if.frac = 1'b0;
    assign ahb_if.ratio = ahbpre_r[6:1];

    assign apb1_if.tick_in = sys_src_tick;
    assign apb1_if.gate = apb1pre_r[CSP_BUS_GATE_BIT];
    assign apb1_if.div_en = apb1pre_r[CSP_DIV_EN_BIT];
    assign apb1_if.frac = 1'b0;
    assign apb1_if.ratio = apb1pre_r[6:1];

    assign apb2_if.tick_in = sys_src_tick;
    assign apb2_if.gate = apb2pre_r[CSP_BUS_GATE_BIT];
    assign apb2_if.div_en = apb2pre_r[CSP_DIV_EN_BIT];
    assign apb2_if.frac = 1'b0;
    assign apb2_if.ratio = apb2pre_r[6:1];

    assign mclk_if.tick_in = sys_src_tick;
    assign mclk_if.gate = mclkpre_r[CSP_BUS_GATE_BIT];
    assign mclk_if.div_en = mclkpre_r[CSP_DIV_EN_BIT];
    assign mclk_if.frac = 1'b0;
    assign mclk_if.ratio = mclkpre_r[6:1];

    // Disabled dividers pass ticks through inside each instance
    csp_prescaler #(.RW(CSP_PLL_RATIO_W)) u_pll_pre (.d(pll_if));
    csp_prescaler #(.RW(CSP_USB_RATIO_W)) u_usb_pre (.d(usb_if));
    csp_prescaler #(.RW(CSP_BUS_RATIO_W)) u_ahb_pre (.d(ahb_if));
    csp_prescaler #(.RW(CSP_BUS_RATIO_W)) u_apb1_pre (.d(apb1_if));
    csp_prescaler #(.RW(CSP_BUS_RATIO_W)) u_apb2_pre (.d(apb2_if));
    csp_prescaler #(.RW(CSP_BUS_RATIO_W)) u_mclk_pre (.d(mclk_if));

    // =====================================================
    // Outputs
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pll_ref_tick = pll_if.tick_out;
    assign usb_tick = usb_if.tick_out;
    assign ahb_tick = ahb_if.tick_out;
    assign apb1_tick = apb1_if.tick_out;
    assign apb2_tick = apb2_if.tick_out;
    assign mclk_tick = mclk_if.tick_out;
    assign system_clock = sys_tick_r;
    assign source_select = cur_src_r;

    // =====================================================
    // Assertions
    pll_gate_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        !pllpre_r[CSP_PLL_GATE_BIT] |=> !pll_ref_tick)
        else $error("pll prescaler ticked while gated off");

    apb1_gate_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        !apb1pre_r[CSP_BUS_GATE_BIT] |=> !apb1_tick)
        else $error("apb1 prescaler ticked while gated off");

    pass_through_a: assert property (@(posedge clk) disable iff (!rst_b)
        (apb2pre_r[CSP_BUS_GATE_BIT] && !apb2pre_r[CSP_DIV_EN_BIT]) |=> (apb2_tick == $past(sys_src_tick)))
        else $error("apb2 tick not passed through");

    ahb_div2_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ahb_tick && ahbpre_r == 7'h01 && $past(ahbpre_r) == 7'h01) |=> !ahb_tick)
        else $error("ahb divide by two ticked twice in a row");

    switch_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
        (cur_src != $past(cur_src)) |-> $past(sw_pending) && $past(stab_s2_r[u_switch.tgt_r]))
        else $error("source changed without pending stable update");

    self_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sw_pending && !upd_req && stab_s2_r[u_switch.tgt_r]) |=> !sw_pending)
        else $error("update bit not cleared after switch");

    hold_unstable_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sw_pending && !stab_s2_r[u_switch.tgt_r]) |=> $stable(cur_src))
        else $error("source switched to unstable target");

    reset_source_a: assert property (@(posedge clk)
        !rst_b |=> (cur_src == CSP_SYS_INT8) && !sw_pending)
        else $error("source not internal 8 MHz after reset");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        (setup && !pwrite && hit_ahbpre) |=> (prdata[31:7] == 25'h0))
        else $error("reserved bits read nonzero");
endmodule
